// ==== caf_acceptance_filter.sv ====
// Acceptance filter: standard list config and extended element evaluation.
//
// Design decisions made here: the Wishbone slave port and the address map.
module caf_acceptance_filter
    import caf_pkg::*;
#(
    parameter int NEXT = 16,
    parameter int EAW  = 5
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        frameValid,
    input  wire logic [28:0] frameId,
    output logic             frameReady,
    output logic             resultValid,
    output logic [2:0]       resultDest,
    output logic [5:0]       resultIndex,
    output logic             highPriorityMatchIrq,
    output logic [7:0]       stdListSize,
    output logic [15:0]      stdListStartAddr
);

    ////////////////////////////////////////////////////////////////////////
    // Operation
    // - List size lives in bits 23:16, start address in bits 15:0.
    // - Size zero means no standard elements; 1..128 gives element count.
    // - Any size above 128 acts as 128 elements.
    // - Start address is a word address; bits 1:0 unused.
    // - Start address bits 1:0 always read back as zero.
    // - Check enabled extended elements in order; stop at first match.
    // - First word: config in 31:29, first identifier in 28:0.
    // - Codes 4, 5, 6 set priority flag and raise enabled interrupt.
    // - Priority match updates the priority message status register.
    // - Code 0 disables an element; it is skipped.
    // - Code 1 stores in FIFO 0, code 2 in FIFO 1.
    // - Code 3 rejects the matching frame.
    // - Code 4 flags only; 5 flags plus FIFO 0; 6 flags plus FIFO 1.
    // - Code 7 stores to dedicated buffer; filter type ignored.
    // - Dedicated buffer match is exact after the global mask only.
    // - Second word: filter type 31:30, second identifier 28:0.
    // - Type 0 is an inclusive masked range from first to second.
    // - Type 1 matches either identifier.
    // - Type 2 compares first identifier under the second as mask.
    // - Type 3 is an inclusive range without the global mask.
    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0]  std_list_size;
        logic [13:0] sa;
        logic        cce;
        logic        init;
        logic [28:0] xmask;
        logic [5:0]  extCount;
        logic        hpmFlag;
        logic        hpmIe;
        logic [31:0] high_priority_msg_status;
        logic        ack;
        logic [31:0] rdat;
        caf_state_t  st;
        logic [28:0] id;
        logic [EAW:0] idx;
        logic [31:0] w0;
        logic        resV;
        logic [2:0]  dest;
        logic [5:0]  resIdx;
    } caf_regs_t;

    caf_regs_t r_ff;
    caf_regs_t nxt_r;

    logic [31:0]    ramRd;
    logic           ramWe;
    logic [EAW-1:0] ramWa;
    logic [EAW-1:0] ramRa;
    logic           wbReq;
    logic           wrAcc;
    logic [7:0]     elemOfs;
    logic [28:0]    mId;
    logic [28:0]    mId1;
    logic [28:0]    mId2;
    logic           hit;
    logic [2:0]     ecfg;
    logic [EAW:0]   lastIdx;

    assign wbReq   = wb_cyc_i && wb_stb_i && !r_ff.ack;
    assign wrAcc   = wbReq && wb_we_i;
    assign elemOfs = wb_adr_i - CAF_OFS_ELEM0;
    assign ramWe   = wrAcc && wb_adr_i >= CAF_OFS_ELEM0
                     && elemOfs[7:2] < 6'(2 * NEXT);
    assign ramWa   = elemOfs[EAW+1:2];
    // Even words hold config and first id, odd words type and second id.
    // The first word is addressed in READ and lands in EVAL; the second
    // follows one cycle later, so DONE sees both words without a stall.
    assign ramRa   = (r_ff.st == CAF_ST_EVAL) ? {r_ff.idx[EAW-2:0], 1'b1}
                                              : {r_ff.idx[EAW-2:0], 1'b0};

    caf_elem_ram #(.AW(EAW)) u_ram (
        .clk    (clk),
        .wrEn   (ramWe),
        .wrAddr (ramWa),
        .wrData (wb_dat_i),
        .rdAddr (ramRa),
        .rdData (ramRd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Match evaluation on the captured first word and live second word.
    always_comb begin
        ecfg = r_ff.w0[CAF_EXT_ELEMENT_CONFIG_HI:CAF_EXT_ELEMENT_CONFIG_LO];
        mId1 = r_ff.w0[CAF_ID_HI:0];
        mId2 = ramRd[CAF_ID_HI:0];
        mId  = r_ff.id & r_ff.xmask;
        hit  = 1'b0;
        if (ecfg == CAF_EC_RXBUF) begin
            hit = (mId == mId1);
        end else begin
            case (caf_ftype_t'(ramRd[CAF_EFT_HI:CAF_EFT_LO]))
                CAF_FT_MRANGE:  hit = mId >= mId1 && mId <= mId2;
                CAF_FT_DUAL:    hit = mId == mId1 || mId == mId2;
                CAF_FT_CLASSIC: hit = (mId & mId2) == (mId1 & mId2);
                CAF_FT_RANGE:   hit = r_ff.id >= mId1 && r_ff.id <= mId2;
                default:        hit = 1'b0;
            endcase
        end
    end

    assign lastIdx = (EAW+1)'(r_ff.extCount);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_r      = r_ff;
        nxt_r.ack  = wbReq;
        nxt_r.resV = 1'b0;
        nxt_r.rdat = CAF_UNMAPPED;
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                CAF_OFS_SFLC:   nxt_r.rdat = {8'h00, r_ff.std_list_size,
                                              r_ff.sa, 2'b00};
                CAF_OFS_CTRL:   nxt_r.rdat = {30'h0, r_ff.init, r_ff.cce};
                CAF_OFS_XMASK:  nxt_r.rdat = {3'b000, r_ff.xmask};
                CAF_OFS_EXTCFG: nxt_r.rdat = {26'h0, r_ff.extCount};
                CAF_OFS_IRQ:    nxt_r.rdat = {31'h0, r_ff.hpmFlag};
                CAF_OFS_IE:     nxt_r.rdat = {31'h0, r_ff.hpmIe};
                CAF_OFS_HIGH_PRIORITY_MSG_STATUS:   nxt_r.rdat = r_ff.high_priority_msg_status;
                CAF_OFS_RES:    nxt_r.rdat = {22'h0, r_ff.resV, r_ff.resIdx,
                                              r_ff.dest};
                default:        nxt_r.rdat = CAF_UNMAPPED;
            endcase
        end
        if (wrAcc) begin
            case (wb_adr_i)
                CAF_OFS_SFLC: begin
                    if (r_ff.cce && r_ff.init) begin
                        if (wb_sel_i[2]) begin
                            nxt_r.std_list_size = wb_dat_i[CAF_LSS_HI:CAF_LSS_LO];
                        end
                        if (wb_sel_i[1]) begin
                            nxt_r.sa[13:6] = wb_dat_i[15:8];
                        end
                        if (wb_sel_i[0]) begin
                            nxt_r.sa[5:0] = wb_dat_i[7:CAF_SA_LO];
                        end
                    end
                end
                CAF_OFS_CTRL: if (wb_sel_i[0]) begin
                    nxt_r.cce  = wb_dat_i[CAF_CCE_BIT];
                    nxt_r.init = wb_dat_i[CAF_INIT_BIT];
                end
                CAF_OFS_XMASK:  nxt_r.xmask = wb_dat_i[CAF_ID_HI:0];
                CAF_OFS_EXTCFG: nxt_r.extCount = (wb_dat_i[5:0] > 6'(NEXT))
                                    ? 6'(NEXT) : wb_dat_i[5:0];
                CAF_OFS_IE:     nxt_r.hpmIe = wb_dat_i[0];
                default: ;
            endcase
        end
        // Write one clears; a set in the same cycle wins below.
        if (wrAcc && wb_adr_i == CAF_OFS_IRQ && wb_dat_i[0]) begin
            nxt_r.hpmFlag = 1'b0;
        end
        case (r_ff.st)
            CAF_ST_IDLE: begin
                if (frameValid) begin
                    nxt_r.id  = frameId;
                    nxt_r.idx = '0;
                    nxt_r.st  = CAF_ST_READ;
                end
            end
            CAF_ST_READ: begin
                if (r_ff.idx >= lastIdx) begin
                    nxt_r.resV = 1'b1;
                    nxt_r.dest = CAF_DST_NONE;
                    nxt_r.st   = CAF_ST_IDLE;
                end else begin
                    nxt_r.st = CAF_ST_EVAL;
                end
            end
            CAF_ST_EVAL: begin
                nxt_r.w0 = ramRd;
                nxt_r.st = CAF_ST_DONE;
            end
            CAF_ST_DONE: begin
                if (ecfg == CAF_EC_DISABLE || !hit) begin
                    nxt_r.idx = r_ff.idx + 1'b1;
                    nxt_r.st  = CAF_ST_READ;
                end else begin
                    nxt_r.resV   = 1'b1;
                    nxt_r.resIdx = 6'(r_ff.idx);
                    nxt_r.st     = CAF_ST_IDLE;
                    case (caf_ecfg_t'(ecfg))
                        CAF_EC_STF0,
                        CAF_EC_PRIF0:  nxt_r.dest = CAF_DST_FIFO0;
                        CAF_EC_STF1,
                        CAF_EC_PRIF1:  nxt_r.dest = CAF_DST_FIFO1;
                        CAF_EC_REJECT: nxt_r.dest = CAF_DST_REJECT;
                        CAF_EC_RXBUF:  nxt_r.dest = CAF_DST_RXBUF;
                        default:       nxt_r.dest = CAF_DST_NONE;
                    endcase
                    if (ecfg[2] && ecfg != CAF_EC_RXBUF) begin
                        nxt_r.hpmFlag = 1'b1;
                        nxt_r.high_priority_msg_status = {8'h00, 2'b00, ecfg, 1'b1,
                                      6'(r_ff.idx), 12'h000};
                    end
                end
            end
            default: nxt_r.st = CAF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            r_ff       <= '0;
            r_ff.std_list_size   <= CAF_RST_SFLC[CAF_LSS_HI:CAF_LSS_LO];
            r_ff.sa    <= CAF_RST_SFLC[CAF_SA_HI:CAF_SA_LO];
            r_ff.xmask <= CAF_RST_XMASK;
            r_ff.st    <= CAF_ST_IDLE;
        end else begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs. The standard list length is clamped for downstream walkers.
    assign wb_ack_o             = r_ff.ack;
    assign wb_dat_o             = r_ff.rdat;
    assign frameReady           = (r_ff.st == CAF_ST_IDLE);
    assign resultValid          = r_ff.resV;
    assign resultDest           = r_ff.dest;
    assign resultIndex          = r_ff.resIdx;
    assign highPriorityMatchIrq = r_ff.hpmFlag && r_ff.hpmIe;
    assign stdListSize          = (r_ff.std_list_size > CAF_LSS_MAX) ? CAF_LSS_MAX
                                                           : r_ff.std_list_size;
    assign stdListStartAddr     = {r_ff.sa, 2'b00};

    ////////////////////////////////////////////////////////////////////////
    a_size_clamp: assert property (@(posedge clk) disable iff (!rstn)
        stdListSize <= CAF_LSS_MAX)
        else $error("list size above limit");
    a_addr_low: assert property (@(posedge clk) disable iff (!rstn)
        wb_ack_o && $past(wb_adr_i) == CAF_OFS_SFLC |-> wb_dat_o[1:0] == 2'b00)
        else $error("start address low bits not zero");
    a_cfg_locked: assert property (@(posedge clk) disable iff (!rstn)
        !(r_ff.cce && r_ff.init) |=> $stable(r_ff.std_list_size) && $stable(r_ff.sa))
        else $error("config changed while locked");
    a_prio_irq: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg inside {3'h4, 3'h5, 3'h6}
        |=> r_ff.hpmFlag)
        else $error("priority flag not set");
    a_reject_dst: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h3
        |=> resultValid && resultDest == CAF_DST_REJECT)
        else $error("reject not reported");
    a_skip_off: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && ecfg == 3'h0 |=> r_ff.st == CAF_ST_READ)
        else $error("disabled element not skipped");
    a_fifo_dst: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h1
        |=> resultDest == CAF_DST_FIFO0)
        else $error("fifo0 destination wrong");
    a_scan_end: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_READ && r_ff.idx >= lastIdx
        |=> resultValid && resultDest == CAF_DST_NONE && frameReady)
        else $error("end of list not reported");
    a_high_priority_msg_status_upd: assert property (@(posedge clk) disable iff (!rstn)
        $rose(r_ff.hpmFlag) |-> r_ff.high_priority_msg_status[18])
        else $error("priority status not updated");
    a_fifo1_dst: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h2
        |=> resultValid && resultDest == CAF_DST_FIFO1)
        else $error("fifo1 destination wrong");
    // A priority hit that also stores must report both at once.
    a_prio_fifo0: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h5
        |=> resultValid && resultDest == CAF_DST_FIFO0 && r_ff.hpmFlag)
        else $error("priority fifo0 hit wrong");
    a_prio_fifo1: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h6
        |=> resultValid && resultDest == CAF_DST_FIFO1 && r_ff.hpmFlag)
        else $error("priority fifo1 hit wrong");
    a_prio_only: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h4
        |=> resultValid && resultDest == CAF_DST_NONE)
        else $error("priority only hit stored");
    a_rxbuf_dst: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && ecfg == 3'h7
        |=> resultValid && resultDest == CAF_DST_RXBUF)
        else $error("dedicated buffer not reported");
    // Codes 1, 2, 3 and 7 must leave the priority flag alone.
    a_no_prio: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && hit && !wrAcc
        && ecfg inside {3'h1, 3'h2, 3'h3, 3'h7}
        |=> $stable(r_ff.hpmFlag))
        else $error("priority flag set by plain code");
    // A clear only wins when no priority hit lands in the same cycle.
    a_clear_flag: assert property (@(posedge clk) disable iff (!rstn)
        wrAcc && wb_adr_i == CAF_OFS_IRQ && wb_dat_i[0]
        && !(r_ff.st == CAF_ST_DONE && hit && ecfg inside {3'h4, 3'h5, 3'h6})
        |=> !r_ff.hpmFlag)
        else $error("priority flag not cleared");
    // Both ends of a plain range must hit when the range is well formed.
    a_range_ends: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && ecfg inside {[3'h1:3'h6]}
        && ramRd[CAF_EFT_HI:CAF_EFT_LO] == CAF_FT_RANGE && mId1 <= mId2
        && (r_ff.id == mId1 || r_ff.id == mId2) |=> resultValid)
        else $error("range end point missed");
    a_miss_next: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.st == CAF_ST_DONE && ecfg != 3'h0 && !hit
        |=> r_ff.st == CAF_ST_READ && r_ff.idx == $past(r_ff.idx) + 1'b1)
        else $error("miss did not advance");
    a_size_pass: assert property (@(posedge clk) disable iff (!rstn)
        r_ff.std_list_size <= CAF_LSS_MAX |-> stdListSize == r_ff.std_list_size)
        else $error("list size altered below limit");
    // An open register must take the size lane as written.
    a_lss_write: assert property (@(posedge clk) disable iff (!rstn)
        wrAcc && wb_adr_i == CAF_OFS_SFLC && wb_sel_i[2]
        && r_ff.cce && r_ff.init
        |=> r_ff.std_list_size == $past(wb_dat_i[CAF_LSS_HI:CAF_LSS_LO]))
        else $error("list size write lost");
endmodule

// ==== caf_acceptance_filter_tb.sv ====
// Self-checking bench for the acceptance filter block.
module caf_acceptance_filter_tb
    import caf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rstn, wbCyc, wbStb, wbWe, ack, frameValid, frameReady;
    logic        resultValid, irq;
    logic [7:0]  wbAdr, stdListSize;
    logic [3:0]  wbSel;
    logic [31:0] wbDat, rdDat, q;
    logic [28:0] frameId;
    logic [2:0]  resultDest;
    logic [5:0]  resultIndex;
    logic [15:0] stdListStartAddr;
    int          nErrors, nCompared;

    caf_acceptance_filter #(.NEXT(16), .EAW(5)) dut (
        .clk(clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(rdDat), .wb_ack_o(ack),
        .frameValid(frameValid), .frameId(frameId),
        .frameReady(frameReady), .resultValid(resultValid),
        .resultDest(resultDest), .resultIndex(resultIndex),
        .highPriorityMatchIrq(irq), .stdListSize(stdListSize),
        .stdListStartAddr(stdListStartAddr));

    caf_frame_src src (
        .clk(clk), .frameValid(frameValid), .frameId(frameId),
        .frameReady(frameReady), .resultValid(resultValid),
        .resultDest(resultDest), .resultIndex(resultIndex));

    always #10 clk = ~clk;

////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic endSim();
        if (nErrors == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Ack is registered, so its value read at the edge is the sampled one.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDat} <= {1'b1, 1'b1, w, 4'hF,
                                                      a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk({31'h0, ack}, 32'h0000_0001);
        q = rdDat;
        {wbCyc, wbStb, wbWe} <= 3'b000;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic elem(input int n, input logic [2:0] c, input logic [1:0] t,
                        input logic [28:0] i1, input logic [28:0] i2);
        wr(CAF_OFS_ELEM0 + 8'(n * 8), {c, i1});
        wr(CAF_OFS_ELEM0 + 8'(n * 8 + 4), {t, 1'b0, i2});
    endtask

    task automatic frame(input logic [28:0] id, input int gap,
                         input logic [2:0] d, input logic [5:0] i);
        logic [2:0] gd;
        logic [5:0] gi;
        logic       ok;
        src.send(id, gap, gd, gi, ok);
        chk({31'h0, ok}, 32'h0000_0001);
        chk({29'h0, gd}, {29'h0, d});
        chk({31'h0, frameReady}, 32'h0000_0001);
        if (d != CAF_DST_NONE) chk({26'h0, gi}, {26'h0, i});
    endtask

////////////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        xfer(1'b0, CAF_OFS_SFLC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk({8'h0, stdListSize, stdListStartAddr}, 32'h0000_0000);
        xfer(1'b0, 8'hFC, 32'h0000_0000);
        chk(q, CAF_UNMAPPED);
    endtask

    task automatic testStdCfg();
        logic [7:0] sz [5];
        logic [7:0] e;
        sz = '{8'h00, 8'h01, 8'h80, 8'h81, 8'hFF};
        wr(CAF_OFS_SFLC, 32'h00C8_ABCF);
        xfer(1'b0, CAF_OFS_SFLC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        // Either enable alone must still leave the register locked.
        for (int m = 1; m < 3; m++) begin
            wr(CAF_OFS_CTRL, 32'(m));
            wr(CAF_OFS_SFLC, 32'h00C8_ABCF);
            xfer(1'b0, CAF_OFS_SFLC, 32'h0000_0000);
            chk(q, 32'h0000_0000);
        end
        wr(CAF_OFS_CTRL, 32'h0000_0003);
        foreach (sz[k]) begin
            e = (sz[k] > CAF_LSS_MAX) ? CAF_LSS_MAX : sz[k];
            wr(CAF_OFS_SFLC, {8'h00, sz[k], 16'hABCF});
            xfer(1'b0, CAF_OFS_SFLC, 32'h0000_0000);
            chk({24'h0, stdListSize}, {24'h0, e});
            chk({16'h0, stdListStartAddr}, 32'h0000_ABCC);
            chk({16'h0, q[15:0]}, 32'h0000_ABCC);
            chk({24'h0, q[23:16]}, {24'h0, sz[k]});
        end
    endtask

    task automatic testList();
        wr(CAF_OFS_EXTCFG, 32'h0000_0005);
        elem(0, CAF_EC_DISABLE, CAF_FT_RANGE, 29'h0, 29'h1FFF_FFFF);
        elem(1, CAF_EC_STF0, CAF_FT_DUAL, 29'h0100, 29'h0200);
        elem(2, CAF_EC_REJECT, CAF_FT_CLASSIC, 29'h3000, 29'h1FFF_F000);
        elem(3, CAF_EC_STF1, CAF_FT_RANGE, 29'h5000, 29'h5010);
        elem(4, CAF_EC_RXBUF, CAF_FT_DUAL, 29'h0777, 29'h0778);
        frame(29'h0200, 0, CAF_DST_FIFO0, 6'h01);
        frame(29'h0100, 3, CAF_DST_FIFO0, 6'h01);
        frame(29'h3ABC, 0, CAF_DST_REJECT, 6'h02);
        frame(29'h5010, 0, CAF_DST_FIFO1, 6'h03);
        frame(29'h4FFF, 0, CAF_DST_NONE, 6'h00);
        frame(29'h0777, 0, CAF_DST_RXBUF, 6'h04);
        frame(29'h0778, 0, CAF_DST_NONE, 6'h00);
        wr(CAF_OFS_XMASK, 32'h1FFF_FF00);
        elem(3, CAF_EC_STF0, CAF_FT_MRANGE, 29'h5000, 29'h5010);
        frame(29'h50FF, 0, CAF_DST_FIFO0, 6'h03);
        elem(3, CAF_EC_STF0, CAF_FT_RANGE, 29'h5000, 29'h5010);
        frame(29'h50FF, 0, CAF_DST_NONE, 6'h00);
        wr(CAF_OFS_XMASK, 32'h1FFF_FFFF);
    endtask

    // Element codes 1 to 7, on an element hit at the low end of its range.
    task automatic testCodes();
        logic [2:0] d [8];
        logic       p;
        d = '{CAF_DST_NONE, CAF_DST_FIFO0, CAF_DST_FIFO1, CAF_DST_REJECT,
              CAF_DST_NONE, CAF_DST_FIFO0, CAF_DST_FIFO1, CAF_DST_RXBUF};
        for (int c = 1; c < 8; c++) begin
            p = (c >= 4 && c <= 6);
            wr(CAF_OFS_IE, {31'h0, c != 4});
            elem(3, 3'(c), CAF_FT_RANGE, 29'h5000, 29'h5010);
            frame(29'h5000, 1, d[c], 6'h03);
            xfer(1'b0, CAF_OFS_IRQ, 32'h0000_0000);
            chk({31'h0, q[0]}, {31'h0, p});
            chk({31'h0, irq}, {31'h0, p && c != 4});
            xfer(1'b0, CAF_OFS_HIGH_PRIORITY_MSG_STATUS, 32'h0000_0000);
            if (p) chk({22'h0, q[21:12]}, {22'h0, 3'(c), 1'b1, 6'h03});
            wr(CAF_OFS_IRQ, 32'h0000_0001);
            chk({31'h0, irq}, 32'h0000_0000);
        end
    endtask

    // A reset in mid-run must wipe the list config left by earlier tests.
    task automatic testMidReset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        xfer(1'b0, CAF_OFS_SFLC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        chk({8'h0, stdListSize, stdListStartAddr}, 32'h0000_0000);
        xfer(1'b0, CAF_OFS_XMASK, 32'h0000_0000);
        chk(q, {3'b000, CAF_RST_XMASK});
    endtask

////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        nErrors++;
        endSim();
    end

    initial begin
        {clk, rstn, wbCyc, wbStb, wbWe} = 5'b00000;
        {wbAdr, wbSel, wbDat} = {8'h00, 4'hF, 32'h0000_0000};
        nErrors = 0;
        nCompared = 0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        testReset();
        testStdCfg();
        testList();
        testCodes();
        testMidReset();
        endSim();
    end
endmodule

// ==== caf_elem_ram.sv ====
// Small element memory holding extended filter words, registered read.
module caf_elem_ram #(
    parameter int AW = 6
) (
    input  wire logic          clk,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [31:0]   wrData,
    input  wire logic [AW-1:0] rdAddr,
    output logic      [31:0]   rdData
);
    logic [31:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// ==== caf_frame_src.sv ====
// Receive engine model that offers extended identifiers to the filter.
module caf_frame_src
    import caf_pkg::*;
(
    input  wire logic        clk,
    output logic             frameValid,
    output logic [28:0]      frameId,
    input  wire logic        frameReady,
    input  wire logic        resultValid,
    input  wire logic [2:0]  resultDest,
    input  wire logic [5:0]  resultIndex
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        frameValid = 1'b0;
        frameId    = 29'h0000_0000;
    end

    // The id is inverted once taken, so a late sample of it cannot pass.
    task automatic send(input logic [28:0] id, input int gap,
                        output logic [2:0] dest, output logic [5:0] idx,
                        output logic ok);
        int n;
        n = 0;
        repeat (gap + 1) @(posedge clk);
        frameValid <= 1'b1;
        frameId    <= id;
        do begin
            @(posedge clk);
            n++;
        end while (frameReady !== 1'b1 && n < 100);
        frameValid <= 1'b0;
        frameId    <= ~id;
        do begin
            @(posedge clk);
            n++;
        end while (resultValid !== 1'b1 && n < 200);
        ok   = (resultValid === 1'b1);
        dest = resultDest;
        idx  = resultIndex;
    endtask
endmodule

// ==== caf_pkg.sv ====
// Package of constants and types for the CAN acceptance filter block.
package caf_pkg;
    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] CAF_OFS_SFLC   = 8'h00;
    localparam logic [7:0] CAF_OFS_CTRL   = 8'h04;
    localparam logic [7:0] CAF_OFS_XMASK  = 8'h08;
    localparam logic [7:0] CAF_OFS_EXTCFG = 8'h0C;
    localparam logic [7:0] CAF_OFS_IRQ    = 8'h10;
    localparam logic [7:0] CAF_OFS_IE     = 8'h14;
    localparam logic [7:0] CAF_OFS_HIGH_PRIORITY_MSG_STATUS   = 8'h18;
    localparam logic [7:0] CAF_OFS_RES    = 8'h1C;
    localparam logic [7:0] CAF_OFS_FRAME  = 8'h20;
    localparam logic [7:0] CAF_OFS_ELEM0  = 8'h40;
    // Field positions.
    localparam int CAF_LSS_HI   = 23;
    localparam int CAF_LSS_LO   = 16;
    localparam int CAF_SA_HI    = 15;
    localparam int CAF_SA_LO    = 2;
    localparam int CAF_EXT_ELEMENT_CONFIG_HI  = 31;
    localparam int CAF_EXT_ELEMENT_CONFIG_LO  = 29;
    localparam int CAF_EFT_HI   = 31;
    localparam int CAF_EFT_LO   = 30;
    localparam int CAF_ID_HI    = 28;
    localparam int CAF_CCE_BIT  = 0;
    localparam int CAF_INIT_BIT = 1;
    // Reset values and limits.
    localparam logic [31:0] CAF_RST_SFLC  = 32'h0000_0000;
    localparam logic [28:0] CAF_RST_XMASK = 29'h1FFF_FFFF;
    localparam logic [7:0]  CAF_LSS_MAX   = 8'h80;
    localparam logic [31:0] CAF_UNMAPPED  = 32'h0000_0000;

    typedef enum logic [2:0] {
        CAF_EC_DISABLE = 3'h0,
        CAF_EC_STF0    = 3'h1,
        CAF_EC_STF1    = 3'h2,
        CAF_EC_REJECT  = 3'h3,
        CAF_EC_PRIO    = 3'h4,
        CAF_EC_PRIF0   = 3'h5,
        CAF_EC_PRIF1   = 3'h6,
        CAF_EC_RXBUF   = 3'h7
    } caf_ecfg_t;

    typedef enum logic [1:0] {
        CAF_FT_MRANGE  = 2'h0,
        CAF_FT_DUAL    = 2'h1,
        CAF_FT_CLASSIC = 2'h2,
        CAF_FT_RANGE   = 2'h3
    } caf_ftype_t;

    // Result destinations reported on the result port.
    typedef enum logic [2:0] {
        CAF_DST_NONE   = 3'h0,
        CAF_DST_FIFO0  = 3'h1,
        CAF_DST_FIFO1  = 3'h2,
        CAF_DST_REJECT = 3'h3,
        CAF_DST_RXBUF  = 3'h4
    } caf_dest_t;

    typedef enum logic [1:0] {
        CAF_ST_IDLE = 2'b00,
        CAF_ST_READ = 2'b01,
        CAF_ST_EVAL = 2'b11,
        CAF_ST_DONE = 2'b10
    } caf_state_t;
endpackage
